//--- guest_state_entry_check.sv
// Guest state entry checker with AHB-Lite registers and interrupt
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module guest_state_entry_check #(
    parameter int LIN_ADDR_W = entry_check_pkg::DEF_LIN_ADDR_W,
    parameter bit SUPPORT_64 = 1'b1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Entry sequencer
    input wire logic entry_req,
    input wire entry_check_pkg::guest_state_s guest_state,
    output logic entry_done,
    output logic entry_fail,
    output entry_check_pkg::check_result_s entry_cause,
    // Interrupt
    output logic irq
);
    import entry_check_pkg::*;

    check_result_s cause_now;
    logic wide_code;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] next_status;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] next_mask;
    logic [31:0] ident_leaf;
    logic [31:0] next_ident_leaf;
    logic [31:0] ident_accum;
    logic [31:0] next_ident_accum;
    logic next_entry_done;
    logic next_entry_fail;
    check_result_s next_entry_cause;
    logic dp_write;
    logic next_dp_write;
    logic [ADDR_DEC_W-1:0] dp_addr;
    logic [ADDR_DEC_W-1:0] next_dp_addr;
    logic [31:0] next_hrdata;
    logic take;
    logic rd_clear;
    logic [STAT_W-1:0] set_bits;

    // ========================================================
    // Field checks
    assign wide_code = guest_state.cs_access[CS_WIDE_CODE_BIT];

    ip_check #(
        .LIN_ADDR_W(LIN_ADDR_W),
        .SUPPORT_64(SUPPORT_64)
    ) u_ip_check (
        .guest_instr_pointer(guest_state.guest_instr_pointer),
        .long_guest(guest_state.long_guest),
        .wide_code(wide_code),
        .high_fail(cause_now.ip_high),
        .canon_fail(cause_now.ip_canon)
    );

    flags_check #(
        .SUPPORT_64(SUPPORT_64)
    ) u_flags_check (
        .guest_flags_field(guest_state.guest_flags_field),
        .long_guest(guest_state.long_guest),
        .event_info(guest_state.event_info),
        .rsvd_fail(cause_now.flags_rsvd),
        .v86_fail(cause_now.v86),
        .if_fail(cause_now.if_clear)
    );

    // ========================================================
    // Verdict to sequencer
    always_comb begin
        next_entry_done = entry_req;
        next_entry_fail = entry_fail;
        next_entry_cause = entry_cause;
        if (entry_req) begin
            next_entry_fail = (cause_now != '0);
            next_entry_cause = cause_now;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_done <= 1'b0;
            entry_fail <= 1'b0;
            entry_cause <= '0;
        end else begin
            entry_done <= next_entry_done;
            entry_fail <= next_entry_fail;
            entry_cause <= next_entry_cause;
        end
    end

    // ========================================================
    // Bus address and data phase
    // Zero wait states: answers never stretch the sequencer path
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
    assign rd_clear = take && !hwrite && (haddr[ADDR_DEC_W-1:0] == REG_STATUS);

    always_comb begin
        next_dp_write = take && hwrite;
        next_dp_addr = take ? haddr[ADDR_DEC_W-1:0] : dp_addr;
        next_hrdata = hrdata;
        if (take && !hwrite) begin
            unique case (haddr[ADDR_DEC_W-1:0])
                REG_STATUS: next_hrdata = {{(32-STAT_W){1'b0}}, status};
                REG_MASK: next_hrdata = {{(32-STAT_W){1'b0}}, mask};
                REG_IDENT_LEAF: next_hrdata = ident_leaf;
                REG_ACCUMULATOR: next_hrdata = ident_accum;
                REG_LAST_CAUSE: next_hrdata = {{(32-$bits(check_result_s)){1'b0}}, entry_cause};
                default: next_hrdata = WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr <= '0;
            hrdata <= WORD_ZERO;
        end else begin
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            hrdata <= next_hrdata;
        end
    end

    // ========================================================
    // Software registers
    always_comb begin
        next_mask = mask;
        next_ident_leaf = ident_leaf;
        if (dp_write && (dp_addr == REG_MASK)) begin
            next_mask = hwdata[STAT_W-1:0];
        end
        if (dp_write && (dp_addr == REG_IDENT_LEAF)) begin
            next_ident_leaf = hwdata;
        end
        next_ident_accum = WORD_ZERO;
        if (ident_leaf == IDENT_LEAF_ADDR_SIZE) begin
            next_ident_accum[ACC_LIN_W_MSB:ACC_LIN_W_LSB] = LIN_ADDR_W[ACC_LIN_W_MSB-ACC_LIN_W_LSB:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask <= STAT_RESET;
            ident_leaf <= WORD_ZERO;
            ident_accum <= WORD_ZERO;
        end else begin
            mask <= next_mask;
            ident_leaf <= next_ident_leaf;
            ident_accum <= next_ident_accum;
        end
    end

    // ========================================================
    // Sticky status and interrupt
    // Set wins over read clear so no verdict is lost
    always_comb begin
        set_bits = '0;
        set_bits[STAT_PASS_BIT] = entry_req && (cause_now == '0);
        set_bits[STAT_FAIL_BIT] = entry_req && (cause_now != '0);
        set_bits[STAT_W-1:STAT_CAUSE_LSB] = entry_req ? cause_now : '0;
        next_status = (rd_clear ? STAT_RESET : status) | set_bits;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= STAT_RESET;
        end else begin
            status <= next_status;
        end
    end

    assign irq = |(status & mask);

    // ========================================================
    // Assertions
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    chk_ip_high_zero: assert property (
        entry_req && SUPPORT_64 && !(guest_state.long_guest && wide_code)
        && (guest_state.guest_instr_pointer[GUEST_W-1:IP_HIGH_LSB] != '0)
        |=> entry_done && entry_fail && entry_cause.ip_high)
        else $error("upper pointer half not rejected");

    chk_ip_canon_mode: assert property (
        entry_done && entry_cause.ip_canon
        |-> $past(entry_req) && $past(guest_state.long_guest) && $past(wide_code) && entry_fail)
        else $error("canonical failure outside long code");

    chk_flags_bit_one: assert property (
        entry_req && !guest_state.guest_flags_field[FLAGS_ONE_BIT]
        |=> entry_fail ##0 entry_cause.flags_rsvd)
        else $error("clear fixed flag bit not rejected");

    chk_flags_clean: assert property (
        entry_req && (guest_state.guest_flags_field == GUEST_W'(2))
        |=> !entry_cause.flags_rsvd ##0 !entry_cause.v86)
        else $error("clean flags rejected");

    chk_v86_long: assert property (
        entry_req && SUPPORT_64 && guest_state.long_guest
        && guest_state.guest_flags_field[FLAGS_V86_BIT]
        |=> entry_cause.v86 && entry_fail)
        else $error("virtual-8086 flag in long guest not rejected");

    chk_if_inject: assert property (
        entry_req && guest_state.event_info[EVT_VALID_BIT]
        && (guest_state.event_info[EVT_TYPE_MSB:EVT_TYPE_LSB] == EVT_TYPE_EXT_INT)
        && !guest_state.guest_flags_field[FLAGS_IF_BIT]
        |=> entry_cause.if_clear && entry_fail)
        else $error("injection with interrupts off not rejected");

    chk_if_no_inject: assert property (
        entry_req && !guest_state.event_info[EVT_VALID_BIT] |=> !entry_cause.if_clear)
        else $error("interrupt flag checked without injection");

    chk_ident_width: assert property (
        ident_leaf == IDENT_LEAF_ADDR_SIZE
        |=> ident_accum[ACC_LIN_W_MSB:ACC_LIN_W_LSB] == LIN_ADDR_W[ACC_LIN_W_MSB-ACC_LIN_W_LSB:0])
        else $error("linear width not reported");

    chk_entry_verdict: assert property (
        entry_req |=> entry_done && (entry_fail == (entry_cause != '0)) ##1 !entry_done || $past(entry_req))
        else $error("verdict does not match causes");

    chk_status_sticky: assert property (
        entry_done && entry_fail |-> status[STAT_FAIL_BIT] ##1 (status[STAT_FAIL_BIT] || $past(rd_clear)))
        else $error("failure not held in status");

    // ========================================================
    // Assertions on passing shapes, reserved flag bits, status and interrupt
    chk_ip_high_pass: assert property (
        entry_req && guest_state.long_guest && wide_code |=> !entry_cause.ip_high)
        else $error("upper pointer half rejected in long code");

    chk_canon_short: assert property (
        entry_req && !(guest_state.long_guest && wide_code) |=> !entry_cause.ip_canon)
        else $error("canonical check applied outside long code");

    chk_flags_b15: assert property (
        entry_req && guest_state.guest_flags_field[FLAGS_RSVD_B15] |=> entry_cause.flags_rsvd && entry_fail)
        else $error("reserved flag bit 15 not rejected");

    chk_flags_b5: assert property (
        entry_req && guest_state.guest_flags_field[FLAGS_RSVD_B5] |=> entry_cause.flags_rsvd && entry_fail)
        else $error("reserved flag bit 5 not rejected");

    chk_flags_upper: assert property (
        entry_req && (guest_state.guest_flags_field[FLAGS_RSVD_MSB_32:FLAGS_RSVD_LSB] != '0)
        |=> entry_cause.flags_rsvd && entry_fail)
        else $error("upper reserved flags not rejected");

    chk_v86_legacy: assert property (
        entry_req && !guest_state.long_guest |=> !entry_cause.v86)
        else $error("virtual-8086 flag rejected outside long guest");

    chk_if_enabled: assert property (
        entry_req && guest_state.guest_flags_field[FLAGS_IF_BIT] |=> !entry_cause.if_clear)
        else $error("enabled interrupts rejected");

    chk_ident_other: assert property (
        ident_leaf != IDENT_LEAF_ADDR_SIZE |=> ident_accum == WORD_ZERO)
        else $error("accumulator not zero for other leaf");

    chk_done_pulse: assert property (
        entry_done |-> $past(entry_req))
        else $error("verdict without request");

    chk_verdict_hold: assert property (
        !entry_done |-> $stable(entry_fail) && $stable(entry_cause))
        else $error("verdict changed without request");

    chk_irq_on_fail: assert property (
        entry_done && entry_fail && mask[STAT_FAIL_BIT] |-> irq)
        else $error("unmasked failure without interrupt");

    chk_set_wins: assert property (
        rd_clear && entry_req |=> status[STAT_PASS_BIT] || status[STAT_FAIL_BIT])
        else $error("verdict lost to status clear");

    chk_pass_status: assert property (
        entry_done && !entry_fail |-> status[STAT_PASS_BIT])
        else $error("pass not held in status");

    cov_entry_pass: cover property (entry_done && !entry_fail);
    cov_entry_fail: cover property (entry_done && entry_fail && irq);
    cov_set_on_clear: cover property (rd_clear && entry_req);
    cov_canon_fail: cover property (entry_done && entry_cause.ip_canon);

endmodule // guest_state_entry_check

//--- entry_check_pkg.sv
// Shared constants and carriers for the guest state entry checker
package entry_check_pkg;

    // ========================================================
    // Guest field layout
    localparam int GUEST_W = 64;
    localparam int IP_HIGH_LSB = 32;
    localparam int CS_WIDE_CODE_BIT = 13;
    localparam int FLAGS_RSVD_LSB = 22;
    localparam int FLAGS_RSVD_MSB_64 = 63;
    localparam int FLAGS_RSVD_MSB_32 = 31;
    localparam int FLAGS_RSVD_B15 = 15;
    localparam int FLAGS_RSVD_B5 = 5;
    localparam int FLAGS_RSVD_B3 = 3;
    localparam int FLAGS_ONE_BIT = 1;
    localparam int FLAGS_V86_BIT = 17;
    localparam int FLAGS_IF_BIT = 9;
    localparam int EVT_VALID_BIT = 31;
    localparam int EVT_TYPE_MSB = 10;
    localparam int EVT_TYPE_LSB = 8;
    localparam logic [2:0] EVT_TYPE_EXT_INT = 3'h0;
    localparam int DEF_LIN_ADDR_W = 48;

    // ========================================================
    // Identification query
    localparam logic [31:0] IDENT_LEAF_ADDR_SIZE = 32'h80000008;
    localparam int ACC_LIN_W_LSB = 8;
    localparam int ACC_LIN_W_MSB = 15;

    // ========================================================
    // Register map and bus
    localparam int ADDR_DEC_W = 8;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_IDENT_LEAF = 8'h08;
    localparam logic [7:0] REG_ACCUMULATOR = 8'h0c;
    localparam logic [7:0] REG_LAST_CAUSE = 8'h10;
    localparam int STAT_PASS_BIT = 0;
    localparam int STAT_FAIL_BIT = 1;
    localparam int STAT_CAUSE_LSB = 2;
    localparam int STAT_W = 7;
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic [STAT_W-1:0] STAT_RESET = 7'h00;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [GUEST_W-1:0] guest_instr_pointer;
        logic [GUEST_W-1:0] guest_flags_field;
        logic long_guest;
        logic [31:0] cs_access;
        logic [31:0] event_info;
    } guest_state_s;

    typedef struct packed {
        logic ip_high;
        logic ip_canon;
        logic flags_rsvd;
        logic v86;
        logic if_clear;
    } check_result_s;

endpackage

//--- ip_check.sv
// Instruction pointer width and canonical form check
`timescale 1ns/100ps
module ip_check #(
    parameter int LIN_ADDR_W = entry_check_pkg::DEF_LIN_ADDR_W,
    parameter bit SUPPORT_64 = 1'b1
) (
    // Guest pointer and code mode
    input wire logic [entry_check_pkg::GUEST_W-1:0] guest_instr_pointer,
    input wire logic long_guest,
    input wire logic wide_code,
    // Verdicts
    output logic high_fail,
    output logic canon_fail
);
    import entry_check_pkg::*;

    // ========================================================
    // Upper half
    // Upper half zero
    assign high_fail = SUPPORT_64 && !(long_guest && wide_code)
        && (guest_instr_pointer[GUEST_W-1:IP_HIGH_LSB] != '0);

    // ========================================================
    // Canonical bits
    generate
        if (LIN_ADDR_W < GUEST_W) begin : g_canon
            logic [GUEST_W-LIN_ADDR_W-1:0] top_bits;
            assign top_bits = guest_instr_pointer[GUEST_W-1:LIN_ADDR_W];
            assign canon_fail = SUPPORT_64 && long_guest && wide_code && !((&top_bits) || !(|top_bits));
        end else begin : g_full
            // Full width: nothing to compare
            assign canon_fail = 1'b0;
        end
    endgenerate

endmodule // ip_check

//--- flags_check.sv
// Guest flags reserved, mode and interrupt-enable check
`timescale 1ns/100ps
module flags_check #(
    parameter bit SUPPORT_64 = 1'b1
) (
    // Guest flags and context
    input wire logic [entry_check_pkg::GUEST_W-1:0] guest_flags_field,
    input wire logic long_guest,
    input wire logic [31:0] event_info,
    // Verdicts
    output logic rsvd_fail,
    output logic v86_fail,
    output logic if_fail
);
    import entry_check_pkg::*;

    logic upper_set;
    logic ext_int;

    // ========================================================
    // Reserved bits
    // Upper reserved span shrinks without 64-bit support
    assign upper_set = SUPPORT_64 ? (guest_flags_field[FLAGS_RSVD_MSB_64:FLAGS_RSVD_LSB] != '0)
                                  : (guest_flags_field[FLAGS_RSVD_MSB_32:FLAGS_RSVD_LSB] != '0);
    assign rsvd_fail = upper_set || guest_flags_field[FLAGS_RSVD_B15] || guest_flags_field[FLAGS_RSVD_B5]
        || guest_flags_field[FLAGS_RSVD_B3] || !guest_flags_field[FLAGS_ONE_BIT];

    // ========================================================
    // Mode and injection
    // No virtual-8086 long
    assign v86_fail = SUPPORT_64 && long_guest && guest_flags_field[FLAGS_V86_BIT];
    assign ext_int = event_info[EVT_VALID_BIT] && (event_info[EVT_TYPE_MSB:EVT_TYPE_LSB] == EVT_TYPE_EXT_INT);
    assign if_fail = ext_int && !guest_flags_field[FLAGS_IF_BIT];

endmodule // flags_check

//--- guest_state_entry_check_tb.sv
// Self-checking testbench for the guest state entry checker
`timescale 1ns/100ps
module guest_state_entry_check_tb;
    import entry_check_pkg::*;
    localparam int LIN_W = 48;
    logic hclk, hresetn, hsel, hwrite, entry_req;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, entry_done, entry_fail, irq;
    guest_state_s guest_state;
    check_result_s entry_cause;
    int errors, samples_checked;
    logic [31:0] lfsr_state;
    logic [6:0] stat_model, mask_model;
    logic [4:0] last_cause;
    guest_state_s gq[$];

    guest_state_entry_check #(.LIN_ADDR_W(LIN_W), .SUPPORT_64(1'b1)) u_guest_state_entry_check (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .entry_req(entry_req), .guest_state(guest_state), .entry_done(entry_done),
        .entry_fail(entry_fail), .entry_cause(entry_cause), .irq(irq)
    );

    // ========================================================
    // Helpers
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t %s: got %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state;
    endfunction

    // Reference verdict, kept apart from the design on purpose
    function automatic logic [4:0] model_cause(guest_state_s g);
        logic lng;
        logic [63:0] ip, fl;
        lng = g.long_guest & g.cs_access[13];
        ip = g.guest_instr_pointer;
        fl = g.guest_flags_field;
        model_cause[4] = !lng && (ip[63:32] != 32'h0);
        model_cause[3] = lng && !((ip[63:LIN_W] == '0) || (&ip[63:LIN_W]));
        model_cause[2] = (fl[63:22] != '0) || fl[15] || fl[5] || fl[3] || !fl[1];
        model_cause[1] = g.long_guest && fl[17];
        model_cause[0] = g.event_info[31] && (g.event_info[10:8] == 3'h0) && !fl[9];
    endfunction

    // ========================================================
    // Bus master
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk(hresp, HRESP_OKAY, "bus response");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, WORD_ZERO, rd);
        chk(rd, exp, msg);
        // Read clears the sticky status
        if (a == REG_STATUS) stat_model = '0;
    endtask

    task automatic set_mask(input logic [31:0] v);
        bus(1'b1, REG_MASK, v, rd);
        mask_model = v[6:0];
    endtask

    // ========================================================
    // Entry sequencer driver, one request per cycle
    task automatic add(input logic [63:0] ip, input logic [63:0] fl, input logic l, input logic [31:0] cs,
                       input logic [31:0] ev);
        guest_state_s g;
        g.guest_instr_pointer = ip;
        g.guest_flags_field = fl;
        g.long_guest = l;
        g.cs_access = cs;
        g.event_info = ev;
        gq.push_back(g);
    endtask

    task automatic run_entries();
        int n;
        logic [4:0] c;
        n = gq.size();
        for (int i = 0; i <= n; i++) begin
            @(posedge hclk);
            if (i < n) begin
                entry_req <= 1'b1;
                guest_state <= gq[i];
            end else begin
                entry_req <= 1'b0;
            end
            #1;
            if (i > 0) begin
                c = model_cause(gq[i-1]);
                last_cause = c;
                stat_model = stat_model | {c, |c, ~|c};
                chk(entry_done, 1'b1, "entry done");
                chk(entry_cause, c, "entry cause");
                chk(entry_fail, |c, "entry verdict");
                chk(irq, |(stat_model & mask_model), "irq level");
            end
        end
        @(posedge hclk);
        #1;
        chk(entry_done, 1'b0, "done pulse width");
        gq.delete();
    endtask

    function automatic guest_state_s rand_guest();
        guest_state_s g;
        logic [31:0] s;
        s = rnd();
        g.long_guest = s[0];
        g.cs_access = rnd();
        g.cs_access[13] = s[1];
        g.guest_instr_pointer = {rnd(), rnd()};
        // Bias toward legal shapes so both verdicts occur often
        if (s[2]) g.guest_instr_pointer[63:32] = '0;
        else if (s[3]) g.guest_instr_pointer[63:47] = {17{s[4]}};
        g.guest_flags_field = {rnd(), rnd()};
        if (s[5]) g.guest_flags_field = (g.guest_flags_field & 64'h00000000003f7fd5) | 64'h2;
        g.event_info = rnd();
        if (s[6]) g.event_info[10:8] = 3'h0;
        return g;
    endfunction

    // ========================================================
    // Main sequence
    initial begin
        errors = 0;
        samples_checked = 0;
        lfsr_state = 32'h663269a5;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        entry_req = 1'b0;
        guest_state = '0;
        stat_model = '0;
        mask_model = '0;
        last_cause = '0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk({entry_done, entry_fail, entry_cause, irq, hreadyout, hrdata}, {9'h001, 32'h0}, "reset outputs");
        rd_chk(REG_MASK, 32'h0, "mask reset");
        rd_chk(REG_IDENT_LEAF, 32'h0, "leaf reset");
        rd_chk(REG_ACCUMULATOR, 32'h0, "acc idle");
        set_mask(32'hffffffff);
        rd_chk(REG_MASK, 32'h7f, "mask width");
        // Unmapped read right after a nonzero one, so stale data would show
        rd_chk(8'h20, 32'h0, "unmapped read");
        bus(1'b1, REG_IDENT_LEAF, 32'h80000008, rd);
        rd_chk(REG_IDENT_LEAF, 32'h80000008, "leaf readback");
        rd_chk(REG_ACCUMULATOR, LIN_W << 8, "acc width");
        bus(1'b1, REG_IDENT_LEAF, 32'h80000007, rd);
        rd_chk(REG_ACCUMULATOR, 32'h0, "acc other leaf");
        bus(1'b1, REG_STATUS, 32'hffffffff, rd);
        rd_chk(REG_STATUS, 32'h0, "status read only");
        set_mask(32'h2);
        // Boundary cases of each check, sent back to back
        add(64'h1000, 64'h2, 1'b0, 32'h0, 32'h0);
        add(64'h100000000, 64'h2, 1'b0, 32'h2000, 32'h0);
        add(64'h100000000, 64'h2, 1'b1, 32'h0, 32'h0);
        add(64'hffff800000000000, 64'h2, 1'b1, 32'h2000, 32'h0);
        add(64'h0000800000000000, 64'h2, 1'b1, 32'h2000, 32'h0);
        add(64'h0001000000000000, 64'h2, 1'b1, 32'h2000, 32'h0);
        add(64'h0, 64'h0, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h8002, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h22, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'ha, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h400002, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h8000000000000002, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h20002, 1'b1, 32'h2000, 32'h0);
        add(64'h0, 64'h20002, 1'b0, 32'h0, 32'h0);
        add(64'h0, 64'h2, 1'b0, 32'h0, 32'h80000000);
        add(64'h0, 64'h202, 1'b0, 32'h0, 32'h80000000);
        add(64'h0, 64'h2, 1'b0, 32'h0, 32'h80000100);
        add(64'h0, 64'h2, 1'b0, 32'h0, 32'h00000000);
        run_entries();
        rd_chk(REG_STATUS, {25'h0, stat_model}, "status sticky");
        chk(irq, 1'b0, "irq after clear");
        rd_chk(REG_LAST_CAUSE, {27'h0, last_cause}, "last cause");
        // Random guests under a random mask
        for (int k = 0; k < 3; k++) begin
            set_mask(rnd() & 32'h7f);
            repeat (40) gq.push_back(rand_guest());
            run_entries();
            rd_chk(REG_STATUS, {25'h0, stat_model}, "status random");
            chk(irq, 1'b0, "irq random clear");
            rd_chk(REG_LAST_CAUSE, {27'h0, last_cause}, "last cause random");
        end
        // Entry taken on the edge of a status read: the set must survive the clear
        gq.push_back(rand_guest());
        fork
            rd_chk(REG_STATUS, {25'h0, stat_model}, "status before set");
            begin
                @(posedge hclk);
                entry_req <= 1'b1;
                guest_state <= gq[0];
                @(posedge hclk);
                entry_req <= 1'b0;
            end
        join
        last_cause = model_cause(gq.pop_front());
        stat_model = {last_cause, |last_cause, ~|last_cause};
        rd_chk(REG_STATUS, {25'h0, stat_model}, "status set wins");
        print_verdict();
    end

    // ========================================================
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #100000;
        errors++;
        print_verdict();
    end
endmodule // guest_state_entry_check_tb
